/* File: src/trace_buffer_regs.vh */
// Constants of the trace message buffer: page select codes, lengths,
// thresholds and reset values. Definitions only; included by bare name.
`ifndef TRACE_BUFFER_REGS_VH
`define TRACE_BUFFER_REGS_VH

// Indirect address layout: page select in [7:6], byte index in [5:0]
`define IND_PAGE_MSB      7
`define IND_PAGE_LSB      6
`define IND_INDEX_MSB     5
`define IND_INDEX_LSB     0

// Page select codes
`define PAGE_CAPTURE      2'h0
`define PAGE_EXPECTED     2'h1
`define PAGE_TRANSMIT     2'h2

// Last byte index of a 16-byte and a 64-byte message
`define LAST_INDEX_16     6'h0F
`define LAST_INDEX_64     6'h3F

// Delimiters of the 64-byte message
`define CHAR_CR           8'h0D
`define CHAR_LF           8'h0A
`define CHAR_NULL         8'h00

// Trace persistency and unstable figures
`define TRACE_PERSIST_3   3'h3
`define TRACE_PERSIST_5   3'h5
`define TRACE_UNSTABLE_MAX 4'h8

// Overhead byte persistency and unstable figures
`define BYTE_PERSIST      3'h5
`define BYTE_UNSTABLE_MAX 3'h5

// Signal label special values
`define LABEL_UNEQUIPPED  8'h00
`define LABEL_EQUIPPED    8'h01

// Reset values
`define RESET_BYTE        8'h00
`define RESET_INDEX       6'h00

`endif

/* File: src/trace_page_ram.v */
// One 64-byte page of flip-flop storage, one write port, two read ports.
// Assumes a single clock; reads are combinational on the index.
`timescale 1ns/1ns
`default_nettype none
`include "trace_buffer_regs.vh"

module trace_page_ram (
	input  wire       ref_clk,
	input  wire       reset_n,
	input  wire       wr_en,
	input  wire [5:0] wr_index,
	input  wire [7:0] wr_data,
	input  wire [5:0] rd_index_a,
	output wire [7:0] rd_data_a,
	input  wire [5:0] rd_index_b,
	output wire [7:0] rd_data_b
);
	reg [7:0] mem [0:63];
	integer   i;

	always @(posedge ref_clk) begin
		if (!reset_n) begin
			for (i = 0; i < 64; i = i + 1) begin
				mem[i] <= `RESET_BYTE;
			end
		end else if (wr_en) begin
			mem[wr_index] <= wr_data;
		end
	end

	assign rd_data_a = mem[rd_index_a];
	assign rd_data_b = mem[rd_index_b];
endmodule
`default_nettype wire

/* File: src/overhead_byte_receiver.v */
// Persistency and compare for one overhead byte (signal label or sync status).
// Assumes one byte strobe per frame from the overhead processor on ref_clk.
`timescale 1ns/1ns
`default_nettype none
`include "trace_buffer_regs.vh"

module overhead_byte_receiver #(
	parameter LABEL_MODE = 1
) (
	input  wire       ref_clk,
	input  wire       reset_n,
	input  wire       byte_valid,
	input  wire [7:0] byte_in,
	input  wire [7:0] expected,
	output reg  [7:0] accepted,
	output reg  [2:0] unstable_count,
	output reg        unstable_alarm,
	output reg        mismatch_alarm
);
	reg  [7:0] previous;
	reg  [2:0] repeat_count;
	wire       changed = byte_in != previous;
	wire       persist_hit = !changed && (repeat_count + 3'h1 == `BYTE_PERSIST);
	reg  [2:0] next_unstable;

	function byte_match;
		input [7:0] exp_val;
		input [7:0] rcv_val;
		input       label_mode;
		begin
			if (!label_mode) begin
				byte_match = exp_val == rcv_val;
			end else if (exp_val == `LABEL_UNEQUIPPED) begin
				byte_match = rcv_val == `LABEL_UNEQUIPPED;
			end else if (exp_val == `LABEL_EQUIPPED) begin
				byte_match = rcv_val != `LABEL_UNEQUIPPED;
			end else begin
				byte_match = rcv_val == `LABEL_EQUIPPED || rcv_val == exp_val;
			end
		end
	endfunction

	always @* begin
		next_unstable = unstable_count;
		if (persist_hit) begin
			next_unstable = 3'h0;
		end else if (changed && unstable_count != `BYTE_UNSTABLE_MAX) begin
			next_unstable = unstable_count + 3'h1;
		end
	end

	always @(posedge ref_clk) begin
		if (!reset_n) begin
			previous       <= `RESET_BYTE;
			accepted       <= `RESET_BYTE;
			repeat_count   <= 3'h0;
			unstable_count <= 3'h0;
			unstable_alarm <= 1'b0;
			mismatch_alarm <= 1'b0;
		end else begin
			mismatch_alarm <= !byte_match(expected, accepted, LABEL_MODE[0]);
			if (byte_valid) begin
				previous       <= byte_in;
				unstable_count <= next_unstable;
				unstable_alarm <= next_unstable == `BYTE_UNSTABLE_MAX;
				if (changed) begin
					repeat_count <= 3'h1;
				end else if (persist_hit) begin
					repeat_count <= 3'h0;
					accepted     <= byte_in;
				end else begin
					repeat_count <= repeat_count + 3'h1;
				end
			end
		end
	end
endmodule
`default_nettype wire

/* File: src/trace_message_buffer.v */
// Trace message buffer: receive framer, persistency and compare for the
// trace message, two overhead byte receivers, and the transmit page.
// Assumes all strobes come from logic on ref_clk; no synchronisers needed.
`timescale 1ns/1ns
`default_nettype none
`include "trace_buffer_regs.vh"

module trace_message_buffer (
	input  wire       ref_clk,
	input  wire       reset_n,
	input  wire       msg_len_64,
	input  wire       frame_align_en,
	input  wire       persist_five,
	input  wire       rx_trace_valid,
	input  wire [7:0] rx_trace_byte,
	input  wire       label_valid,
	input  wire [7:0] label_byte,
	input  wire [7:0] expected_label,
	input  wire       sync_valid,
	input  wire [7:0] sync_byte,
	input  wire [7:0] expected_sync,
	input  wire       tx_trace_req,
	input  wire       tx_null_en,
	input  wire       tx_page_busy,
	input  wire       ind_addr_wr,
	input  wire       ind_data_wr,
	input  wire       ind_data_rd,
	input  wire [7:0] ind_wdata,
	output reg  [7:0] ind_addr,
	output reg  [7:0] ind_rdata,
	output reg  [7:0] tx_trace_byte,
	output reg  [3:0] trace_unstable_count,
	output reg        trace_unstable_alarm,
	output reg        trace_mismatch_alarm,
	output reg        trace_accept_pulse,
	output wire [7:0] label_accepted,
	output wire [2:0] label_unstable_count,
	output wire       label_unstable_alarm,
	output wire       label_mismatch_alarm,
	output wire [7:0] sync_accepted,
	output wire [2:0] sync_unstable_count,
	output wire       sync_unstable_alarm,
	output wire       sync_mismatch_alarm
);
	// Receive framer state
	reg  [5:0] rx_pos;
	reg  [7:0] prev_byte_1;
	reg  [7:0] prev_byte_2;
	reg        msg_diff;
	reg        msg_zero;
	reg        msg_exp;
	reg  [2:0] persist_count;

	// Transmit state
	reg  [5:0] tx_pos;

	// Page read data
	wire [7:0] cap_old;
	wire [7:0] cap_ind;
	wire [7:0] exp_old;
	wire [7:0] exp_ind;
	wire [7:0] tx_data;
	wire [7:0] tx_ind;

	// Indirect decode
	wire [1:0] ind_page  = ind_addr[`IND_PAGE_MSB:`IND_PAGE_LSB];
	wire [5:0] ind_index = ind_addr[`IND_INDEX_MSB:`IND_INDEX_LSB];

	function page_hit;
		input [1:0] page;
		input [1:0] code;
		begin
			page_hit = page == code;
		end
	endfunction

	wire exp_wr = ind_data_wr && page_hit(ind_page, `PAGE_EXPECTED);
	wire txp_wr = ind_data_wr && page_hit(ind_page, `PAGE_TRANSMIT);

	// Framing
	wire [5:0] last_index = msg_len_64 ? `LAST_INDEX_64 : `LAST_INDEX_16;
	wire       start_16   = rx_trace_byte[7];
	wire       start_64   = prev_byte_2 == `CHAR_CR && prev_byte_1 == `CHAR_LF;
	wire       is_start   = msg_len_64 ? start_64 : start_16;
	wire       realign    = frame_align_en && is_start && rx_pos != `RESET_INDEX;
	wire [5:0] wr_index   = realign ? `RESET_INDEX : rx_pos;
	wire       msg_end    = wr_index == last_index;

	// Running message comparison, restarted on realignment
	wire base_diff  = realign ? 1'b0 : msg_diff;
	wire base_zero  = realign ? 1'b1 : msg_zero;
	wire base_exp   = realign ? 1'b1 : msg_exp;
	wire diff_total = base_diff | (rx_trace_byte != cap_old);
	wire zero_total = base_zero & (rx_trace_byte == `RESET_BYTE);
	wire exp_total  = base_exp & (rx_trace_byte == exp_old);

	wire [2:0] persist_target = persist_five ? `TRACE_PERSIST_5 : `TRACE_PERSIST_3;
	wire       accept = rx_trace_valid && msg_end && !diff_total &&
	                    (persist_count + 3'h1 == persist_target);

	reg [3:0] next_unstable;
	reg [2:0] next_persist;

	always @* begin
		next_unstable = trace_unstable_count;
		next_persist  = persist_count;
		if (rx_trace_valid) begin
			if (realign) begin
				next_persist = 3'h0;
			end
			if (accept) begin
				next_persist  = 3'h0;
				next_unstable = 4'h0;
			end else if (msg_end && diff_total) begin
				next_persist = 3'h1;
			end else if (msg_end) begin
				next_persist = persist_count + 3'h1;
			end
			if (!accept && ((msg_end && diff_total) || realign) &&
			    trace_unstable_count != `TRACE_UNSTABLE_MAX) begin
				next_unstable = trace_unstable_count + 4'h1;
			end
		end
	end

	always @(posedge ref_clk) begin
		if (!reset_n) begin
			rx_pos               <= `RESET_INDEX;
			prev_byte_1          <= `RESET_BYTE;
			prev_byte_2          <= `RESET_BYTE;
			msg_diff             <= 1'b0;
			msg_zero             <= 1'b1;
			msg_exp              <= 1'b1;
			persist_count        <= 3'h0;
			trace_unstable_count <= 4'h0;
			trace_unstable_alarm <= 1'b0;
			trace_mismatch_alarm <= 1'b0;
			trace_accept_pulse   <= 1'b0;
		end else begin
			trace_accept_pulse <= accept;
			if (rx_trace_valid) begin
				prev_byte_2          <= prev_byte_1;
				prev_byte_1          <= rx_trace_byte;
				rx_pos               <= msg_end ? `RESET_INDEX : wr_index + 6'h01;
				persist_count        <= next_persist;
				trace_unstable_count <= next_unstable;
				trace_unstable_alarm <= next_unstable == `TRACE_UNSTABLE_MAX;
				if (msg_end) begin
					msg_diff <= 1'b0;
					msg_zero <= 1'b1;
					msg_exp  <= 1'b1;
				end else begin
					msg_diff <= diff_total;
					msg_zero <= zero_total;
					msg_exp  <= exp_total;
				end
				if (accept) begin
					trace_mismatch_alarm <= !(zero_total || exp_total);
				end
			end
		end
	end

	// Transmit page readout
	always @(posedge ref_clk) begin
		if (!reset_n) begin
			tx_pos        <= `RESET_INDEX;
			tx_trace_byte <= `CHAR_NULL;
		end else if (tx_trace_req) begin
			tx_pos <= (tx_pos == last_index) ? `RESET_INDEX : tx_pos + 6'h01;
			if (tx_null_en && tx_page_busy) begin
				tx_trace_byte <= `CHAR_NULL;
			end else begin
				tx_trace_byte <= tx_data;
			end
		end
	end

	// Indirect address and data access
	always @(posedge ref_clk) begin
		if (!reset_n) begin
			ind_addr  <= `RESET_BYTE;
			ind_rdata <= `RESET_BYTE;
		end else begin
			if (ind_addr_wr) begin
				ind_addr <= ind_wdata;
			end else if (ind_data_wr || ind_data_rd) begin
				ind_addr <= {ind_page, ind_index + 6'h01};
			end
			case (ind_page)
				`PAGE_CAPTURE:  ind_rdata <= cap_ind;
				`PAGE_EXPECTED: ind_rdata <= exp_ind;
				`PAGE_TRANSMIT: ind_rdata <= tx_ind;
				default:        ind_rdata <= `RESET_BYTE;
			endcase
		end
	end

	trace_page_ram u_capture_page (
		.ref_clk    (ref_clk),
		.reset_n    (reset_n),
		.wr_en      (rx_trace_valid),
		.wr_index   (wr_index),
		.wr_data    (rx_trace_byte),
		.rd_index_a (wr_index),
		.rd_data_a  (cap_old),
		.rd_index_b (ind_index),
		.rd_data_b  (cap_ind)
	);

	trace_page_ram u_expected_page (
		.ref_clk    (ref_clk),
		.reset_n    (reset_n),
		.wr_en      (exp_wr),
		.wr_index   (ind_index),
		.wr_data    (ind_wdata),
		.rd_index_a (wr_index),
		.rd_data_a  (exp_old),
		.rd_index_b (ind_index),
		.rd_data_b  (exp_ind)
	);

	trace_page_ram u_transmit_page (
		.ref_clk    (ref_clk),
		.reset_n    (reset_n),
		.wr_en      (txp_wr),
		.wr_index   (ind_index),
		.wr_data    (ind_wdata),
		.rd_index_a (tx_pos),
		.rd_data_a  (tx_data),
		.rd_index_b (ind_index),
		.rd_data_b  (tx_ind)
	);

	overhead_byte_receiver #(
		.LABEL_MODE (1)
	) u_label_receiver (
		.ref_clk        (ref_clk),
		.reset_n        (reset_n),
		.byte_valid     (label_valid),
		.byte_in        (label_byte),
		.expected       (expected_label),
		.accepted       (label_accepted),
		.unstable_count (label_unstable_count),
		.unstable_alarm (label_unstable_alarm),
		.mismatch_alarm (label_mismatch_alarm)
	);

	overhead_byte_receiver #(
		.LABEL_MODE (0)
	) u_sync_receiver (
		.ref_clk        (ref_clk),
		.reset_n        (reset_n),
		.byte_valid     (sync_valid),
		.byte_in        (sync_byte),
		.expected       (expected_sync),
		.accepted       (sync_accepted),
		.unstable_count (sync_unstable_count),
		.unstable_alarm (sync_unstable_alarm),
		.mismatch_alarm (sync_mismatch_alarm)
	);
endmodule
`default_nettype wire

/* File: test/trace_buffer_assertions.sv */
// Checker of the trace buffer outputs against their causes.
// Assumes one clock domain; sees only the top module's ports.
`timescale 1ns/1ns
`default_nettype none
module trace_buffer_checker (
	input wire logic       ref_clk,
	input wire logic       reset_n,
	input wire logic       tx_trace_req,
	input wire logic       tx_null_en,
	input wire logic       tx_page_busy,
	input wire logic [7:0] tx_trace_byte,
	input wire logic [3:0] trace_unstable_count,
	input wire logic       trace_unstable_alarm,
	input wire logic       trace_accept_pulse,
	input wire logic [7:0] expected_label,
	input wire logic [7:0] label_accepted,
	input wire logic [2:0] label_unstable_count,
	input wire logic       label_unstable_alarm,
	input wire logic       label_mismatch_alarm,
	input wire logic [7:0] expected_sync,
	input wire logic [7:0] sync_accepted,
	input wire logic [2:0] sync_unstable_count,
	input wire logic       sync_unstable_alarm,
	input wire logic       sync_mismatch_alarm
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	// Label table: 1 means mismatch
	function automatic logic lm(input logic [7:0] e, input logic [7:0] r);
		if (e == 8'h00)
			return r != 8'h00;
		if (e == 8'h01)
			return r == 8'h00;
		return !(r == 8'h01 || r == e);
	endfunction
	property p_trace_sat; trace_unstable_count <= 4'h8; endproperty
	a_trace_sat: assert property (p_trace_sat) else $error("trace count over 8");
	property p_trace_alarm; trace_unstable_count == 4'h8 |-> ##[0:1] trace_unstable_alarm; endproperty
	a_trace_alarm: assert property (p_trace_alarm) else $error("trace alarm missing");
	property p_accept; trace_accept_pulse |-> trace_unstable_count == 4'h0
		&& !trace_unstable_alarm; endproperty
	a_accept: assert property (p_accept) else $error("accept left count or alarm");
	property p_pulse; trace_accept_pulse |=> !trace_accept_pulse; endproperty
	a_pulse: assert property (p_pulse) else $error("accept pulse too long");
	property p_label_sat; label_unstable_count <= 3'h5; endproperty
	a_label_sat: assert property (p_label_sat) else $error("label count over 5");
	property p_sync_alarm; sync_unstable_count == 3'h5 |-> ##[0:1] sync_unstable_alarm; endproperty
	a_sync_alarm: assert property (p_sync_alarm) else $error("sync alarm missing");
	property p_label_acc; $changed(label_accepted) |-> label_unstable_count == 3'h0
		&& !label_unstable_alarm; endproperty
	a_label_acc: assert property (p_label_acc) else $error("label accept left alarm");
	property p_label_cmp; $changed(label_accepted) |=>
		label_mismatch_alarm == lm(expected_label, label_accepted); endproperty
	a_label_cmp: assert property (p_label_cmp) else $error("label mismatch wrong");
	property p_sync_cmp; $changed(sync_accepted) |=>
		sync_mismatch_alarm == (sync_accepted != expected_sync); endproperty
	a_sync_cmp: assert property (p_sync_cmp) else $error("sync mismatch wrong");
	property p_tx_null; tx_trace_req && tx_page_busy && tx_null_en |=> tx_trace_byte == 8'h00;
		endproperty
	a_tx_null: assert property (p_tx_null) else $error("null not sent");
endmodule
bind trace_message_buffer trace_buffer_checker chk (.ref_clk(ref_clk), .reset_n(reset_n),
	.tx_trace_req(tx_trace_req), .tx_null_en(tx_null_en), .tx_page_busy(tx_page_busy),
	.tx_trace_byte(tx_trace_byte), .trace_unstable_count(trace_unstable_count),
	.trace_unstable_alarm(trace_unstable_alarm), .trace_accept_pulse(trace_accept_pulse),
	.expected_label(expected_label), .label_accepted(label_accepted),
	.label_unstable_count(label_unstable_count), .label_unstable_alarm(label_unstable_alarm),
	.label_mismatch_alarm(label_mismatch_alarm), .expected_sync(expected_sync),
	.sync_accepted(sync_accepted), .sync_unstable_count(sync_unstable_count),
	.sync_unstable_alarm(sync_unstable_alarm), .sync_mismatch_alarm(sync_mismatch_alarm));
`default_nettype wire

/* File: test/overhead_feeder.sv */
// Model of the upstream overhead processors feeding trace and overhead bytes.
// Assumes its tasks are entered 5 ns after a rising edge.
`timescale 1ns/1ns
`default_nettype none
module overhead_feeder (
	input  wire logic       ref_clk,
	output var  logic       rx_trace_valid,
	output var  logic [7:0] rx_trace_byte,
	output var  logic       oh_valid,
	output var  logic [7:0] oh_byte
);
	initial begin
		rx_trace_valid = 1'b0;
		rx_trace_byte = 8'h00;
		oh_valid = 1'b0;
		oh_byte = 8'h00;
	end
	// Idle data shows the inverse, never a stale copy
	task automatic send_trace(input logic [7:0] b);
		rx_trace_valid = 1'b1;
		rx_trace_byte = b;
		@(posedge ref_clk);
		#5;
		rx_trace_valid = 1'b0;
		rx_trace_byte = ~b;
		@(posedge ref_clk);
		#5;
	endtask
	// One label and sync byte per frame
	task automatic send_oh(input logic [7:0] b);
		oh_valid = 1'b1;
		oh_byte = b;
		@(posedge ref_clk);
		#5;
		oh_valid = 1'b0;
		oh_byte = ~b;
		@(posedge ref_clk);
		#5;
	endtask
endmodule
`default_nettype wire

/* File: test/trace_message_buffer_tb_top.sv */
// Self-checking bench of the trace message buffer.
// Assumes the feeder model upstream; the bench plays the processor.
`timescale 1ns/1ns
`default_nettype none
module trace_message_buffer_tb_top;
	logic       ref_clk = 1'b0, reset_n = 1'b0, ind_addr_wr = 1'b0, ind_data_wr = 1'b0;
	logic       tx_trace_req = 1'b0, tx_null_en = 1'b0, tx_page_busy = 1'b0;
	logic [7:0] ind_wdata = 8'h00, expected_label = 8'h00, expected_sync = 8'h00;
	logic [7:0] msg [16], pe [10], pr [10], r;
	wire logic rv, ov, tmm, tap, lmm, smm, sua, tua;
	wire logic [7:0] rb, ob, ind_rdata, tx_trace_byte, label_accepted;
	wire logic [3:0] tuc;
	wire logic [2:0] suc;
	typedef struct {int k; logic [7:0] v;} note_t;
	note_t q [$];
	event got;
	int mismatches = 0, checks = 0, cycles = 0, seed = 32'h1905, tap_cnt = 0;
	string nm [11] = '{"trace_count", "trace_mismatch", "accept_pulse", "ind_rdata",
		"tx_byte", "label_accepted", "label_mismatch", "sync_mismatch", "sync_count", "sync_alarm",
		"trace_alarm"};
	overhead_feeder fd (.ref_clk(ref_clk), .rx_trace_valid(rv), .rx_trace_byte(rb),
		.oh_valid(ov), .oh_byte(ob));
	trace_message_buffer dut (.ref_clk(ref_clk), .reset_n(reset_n), .msg_len_64(1'b0),
		.frame_align_en(1'b1), .persist_five(1'b0), .rx_trace_valid(rv), .rx_trace_byte(rb),
		.label_valid(ov), .label_byte(ob), .expected_label(expected_label), .sync_valid(ov),
		.sync_byte(ob), .expected_sync(expected_sync), .tx_trace_req(tx_trace_req),
		.tx_null_en(tx_null_en), .tx_page_busy(tx_page_busy), .ind_addr_wr(ind_addr_wr),
		.ind_data_wr(ind_data_wr), .ind_data_rd(1'b0), .ind_wdata(ind_wdata), .ind_addr(),
		.ind_rdata(ind_rdata), .tx_trace_byte(tx_trace_byte), .trace_unstable_count(tuc),
		.trace_unstable_alarm(tua), .trace_mismatch_alarm(tmm), .trace_accept_pulse(tap),
		.label_accepted(label_accepted), .label_unstable_count(), .label_unstable_alarm(),
		.label_mismatch_alarm(lmm), .sync_accepted(), .sync_unstable_count(suc),
		.sync_unstable_alarm(sua), .sync_mismatch_alarm(smm));
	always #25 ref_clk = ~ref_clk;
	function automatic logic [7:0] obs(input int k);
		logic [7:0] s [11];
		// Pulse slot: pulses counted so far, then the pulse itself
		s = '{{4'h0, tuc}, {7'h00, tmm}, {tap_cnt[6:0], tap}, ind_rdata, tx_trace_byte,
			label_accepted, {7'h00, lmm}, {7'h00, smm}, {5'h00, suc}, {7'h00, sua},
			{7'h00, tua}};
		return s[k];
	endfunction
	function automatic logic [7:0] lm(input logic [7:0] e, input logic [7:0] v);
		if (e == 8'h00)
			return {7'h00, v != 8'h00};
		if (e == 8'h01)
			return {7'h00, v == 8'h00};
		return {7'h00, !(v == 8'h01 || v == e)};
	endfunction
	task automatic test_done;
		if (mismatches == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] s);
		checks++;
		if (s !== e) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic note(input int k, input logic [7:0] v);
		q.push_back('{k, v});
		-> got;
	endtask
	always @(got) begin
		while (q.size() > 0) begin
			cmp(nm[q[0].k], q[0].v, obs(q[0].k));
			void'(q.pop_front());
		end
	end
	always @(posedge ref_clk) begin
		cycles++;
		if (tap)
			tap_cnt++;
		if (cycles == 5000) begin
			mismatches++;
			test_done;
		end
	end
	task automatic tick;
		@(posedge ref_clk);
		#5;
	endtask
	task automatic set_addr(input logic [7:0] a);
		ind_addr_wr = 1'b1;
		ind_wdata = a;
		tick;
		ind_addr_wr = 1'b0;
		tick;
	endtask
	task automatic wr(input logic [7:0] d);
		ind_data_wr = 1'b1;
		ind_wdata = d;
		tick;
		ind_data_wr = 1'b0;
		tick;
	endtask
	task automatic req;
		tx_trace_req = 1'b1;
		tick;
		tx_trace_req = 1'b0;
		tick;
	endtask
	initial begin
		repeat (12) @(posedge ref_clk);
		#5;
		reset_n = 1'b1;
		for (int i = 0; i < 16; i++)
			msg[i] = (i == 0) ? (8'($random(seed)) | 8'h80) : (8'($random(seed)) & 8'h7F);
		msg[1] = msg[1] | 8'h08;
		set_addr(8'h40);
		for (int i = 0; i < 16; i++)
			wr(i == 5 ? msg[i] ^ 8'h01 : msg[i]);
		for (int j = 0; j < 8; j++)
			for (int i = 0; i < 16; i++)
				fd.send_trace(i == 1 ? 8'(j) : msg[i]);
		note(0, 8'h08);
		note(10, 8'h01);
		repeat (3)
			for (int i = 0; i < 16; i++)
				fd.send_trace(msg[i]);
		note(0, 8'h00);
		note(1, 8'h01);
		note(10, 8'h00);
		tick;
		note(2, 8'h02);
		tick;
		note(2, 8'h02);
		set_addr(8'h00);
		note(3, msg[0]);
		set_addr(8'h05);
		note(3, msg[5]);
		set_addr(8'h80);
		wr(msg[2]);
		wr(msg[3]);
		tx_null_en = 1'b1;
		tx_page_busy = 1'b1;
		req;
		note(4, 8'h00);
		tx_page_busy = 1'b0;
		req;
		note(4, msg[3]);
		r = 8'h02 + 8'({$random(seed)} % 252);
		pe = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, r, r, r, r};
		pr = '{8'h00, 8'h01, r, 8'h00, 8'h01, r, 8'h00, 8'h01, r, r + 8'h01};
		for (int i = 0; i < 10; i++) begin
			expected_label = pe[i];
			expected_sync = pe[i];
			repeat (5) fd.send_oh(pr[i]);
			tick;
			note(5, pr[i]);
			note(6, lm(pe[i], pr[i]));
			note(7, {7'h00, pe[i] != pr[i]});
		end
		for (int i = 0; i < 6; i++)
			fd.send_oh(8'h10 + 8'(i));
		note(8, 8'h05);
		note(9, 8'h01);
		repeat (5) fd.send_oh(8'h20);
		note(8, 8'h00);
		note(9, 8'h00);
		test_done;
	end
endmodule
`default_nettype wire
